// [core/sicm_pkg.sv]
// Constants for the stage input connection matrix block.
// Assumes a 32-bit classic Wishbone slave and a 125 MHz system clock.
package sicm_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [9:0] BASE_IDX     = 10'h080; // stage 0 lower word
  localparam logic [9:0] STAGE_STRIDE = 10'h008; // words per stage
  localparam logic [2:0] LOW_WORD     = 3'h0;
  localparam logic [2:0] HIGH_WORD    = 3'h1;
  localparam logic [9:0] STATUS_IDX   = 10'h060; // block status word

  // Sizes
  localparam int NUM_STAGES = 12;
  localparam int NUM_INPUTS = 13;
  localparam int LOW_INPUTS = 7;  // inputs held in the lower word
  localparam int ADR_W      = 12; // byte address bits decoded
  localparam int STAGE_W    = 4;
  localparam int OFFSET_W   = 6;

  // Per-input route selection codes
  localparam logic [1:0] ROUTE_OPEN = 2'h0;
  localparam logic [1:0] ROUTE_NEG  = 2'h1;
  localparam logic [1:0] ROUTE_POS  = 2'h2;
  localparam logic [1:0] ROUTE_BIAS = 2'h3;

  // Measurement mode codes
  localparam logic [1:0] MODE_FORBIDDEN = 2'h0;
  localparam logic [1:0] MODE_SE_POS    = 2'h1;
  localparam logic [1:0] MODE_SE_NEG    = 2'h2;
  localparam logic [1:0] MODE_DIFF      = 2'h3;

  // Field positions inside the upper word
  localparam int MODE_LSB    = 12;
  localparam int NEG_OFF_BIT = 14;
  localparam int POS_OFF_BIT = 15;

  // Bits of the lower word that are stored; the rest read as zero
  localparam logic [15:0] LOW_USED_MASK = 16'h3fff;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // Offset path scale, kept for documentation of the code width
  localparam int OFFSET_STEP_FF  = 320;
  localparam int OFFSET_RANGE_PF = 20;

  // Status word layout
  localparam int ST_STAGE_LSB = 0;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_BUSY_BIT  = 5;

  typedef enum logic [1:0] {
    SICM_BUS_IDLE = 2'b00,
    SICM_BUS_WAIT = 2'b01,
    SICM_BUS_ACK  = 2'b11
  } sicm_bus_state_t;

  typedef enum logic [1:0] {
    SICM_STG_IDLE  = 2'b00,
    SICM_STG_FETCH = 2'b01,
    SICM_STG_APPLY = 2'b11
  } sicm_stg_state_t;

endpackage

// [core/sicm_stage_mem.sv]
// Per-stage connection word storage, one entry per stage.
// Assumes one write port and two independent registered read ports.
`timescale 1ns/1ps
module sicm_stage_mem #(
  parameter int DEPTH = 12,
  parameter int AW    = 4,
  parameter int WIDTH = 32
) (
  input  wire logic                 clk,
  input  wire logic                 wr_en,
  input  wire logic [AW-1:0]        wr_addr,
  input  wire logic [WIDTH/8-1:0]   wr_be,
  input  wire logic [WIDTH-1:0]     wr_data,
  input  wire logic [AW-1:0]        a_addr,
  output logic      [WIDTH-1:0]     a_data,
  input  wire logic [AW-1:0]        b_addr,
  output logic      [WIDTH-1:0]     b_data
);

  // No reset: contents stay undefined until software writes them
  logic [WIDTH-1:0] mem [DEPTH];

  // Byte-lane writes; one process owns the whole array so it has one driver
  always_ff @(posedge clk)
  begin
    for (int g = 0; g < WIDTH/8; g++)
    begin
      if (wr_en && wr_be[g])
      begin
        mem[wr_addr][g*8 +: 8] <= wr_data[g*8 +: 8];
      end
    end
  end

  // Registered reads; old data on a same-cycle write
  always_ff @(posedge clk)
  begin
    a_data <= mem[a_addr];
    b_data <= mem[b_addr];
  end

endmodule

// [core/sicm_top.sv]
// Stage input connection matrix: register file and per-stage switch decode.
// Assumes a classic Wishbone master on clk and a conversion sequencer
// on the same clock that asks for one stage at a time.
`timescale 1ns/1ps

module sicm_top #(
  parameter int NUM_STAGES = sicm_pkg::NUM_STAGES,
  parameter int NUM_INPUTS = sicm_pkg::NUM_INPUTS
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Wishbone classic slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [sicm_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Conversion sequencer side
  input  wire logic                          stage_load,
  input  wire logic [sicm_pkg::STAGE_W-1:0]  stage_sel,
  input  wire logic [sicm_pkg::OFFSET_W-1:0] neg_frontend_offset_value,
  input  wire logic [sicm_pkg::OFFSET_W-1:0] pos_frontend_offset_value,
  output logic                               stage_ready,
  output logic                               stage_busy,
  output logic      [NUM_INPUTS-1:0]         sensor_input_to_neg,
  output logic      [NUM_INPUTS-1:0]         sensor_input_to_pos,
  output logic      [NUM_INPUTS-1:0]         sensor_input_to_bias,
  output logic      [1:0]                    measurement_mode_sel,
  output logic                               mode_fault,
  output logic                               neg_frontend_offset_en,
  output logic                               pos_frontend_offset_en,
  output logic      [sicm_pkg::OFFSET_W-1:0] neg_offset_code,
  output logic      [sicm_pkg::OFFSET_W-1:0] pos_offset_code
);

  // Decode a word index into {hit, is_high, stage}
  function automatic logic [5:0] decode_reg(input logic [9:0] idx);
    logic [9:0] rel;
    logic       hit;
    rel = idx - sicm_pkg::BASE_IDX;
    hit = (idx >= sicm_pkg::BASE_IDX)
          && (rel < 10'(NUM_STAGES) * sicm_pkg::STAGE_STRIDE)
          && (rel[2:0] == sicm_pkg::LOW_WORD || rel[2:0] == sicm_pkg::HIGH_WORD);
    decode_reg = {hit, rel[2:0] == sicm_pkg::HIGH_WORD, rel[6:3]};
  endfunction

  // Decode one two-bit selection into {bias, pos, neg}
  function automatic logic [2:0] decode_route(input logic [1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    unique case (sel)
      sicm_pkg::ROUTE_OPEN: r = 3'b000;
      sicm_pkg::ROUTE_NEG:  r = 3'b001;
      sicm_pkg::ROUTE_POS:  r = 3'b010;
      sicm_pkg::ROUTE_BIAS: r = 3'b100;
    endcase
    decode_route = r;
  endfunction

  // ------------------------------------------------------------------
  // Bus side
  // ------------------------------------------------------------------
  sicm_pkg::sicm_bus_state_t bus_state_q;
  logic [9:0]  bus_idx;
  logic [5:0]  bus_dec;
  logic        bus_hit;
  logic        bus_high;
  logic [3:0]  bus_stage;
  logic        bus_status;
  logic        mem_we;
  logic [3:0]  mem_be;
  logic [31:0] mem_wdata;
  logic [31:0] mem_a_data;
  logic [31:0] mem_b_data;
  logic [31:0] rd_word;
  logic [31:0] wb_dat_q;
  logic        wb_ack_q;
  logic [sicm_pkg::STAGE_W-1:0] stage_q;
  logic        stage_busy_q;
  logic        mode_fault_q;

  // Word index from the byte address; low two bits are dropped, wb_sel_i picks lanes
  assign bus_idx    = 10'(wb_adr_i[sicm_pkg::ADR_W-1:2]);
  assign bus_dec    = decode_reg(bus_idx);
  assign bus_hit    = bus_dec[5];
  assign bus_high   = bus_dec[4];
  assign bus_stage  = bus_dec[3:0];
  assign bus_status = (bus_idx == sicm_pkg::STATUS_IDX);

  // Bus handshake: request seen, one wait for the memory read, then ack
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_state_q <= sicm_pkg::SICM_BUS_IDLE;
    end
    else
    begin
      unique case (bus_state_q)
        sicm_pkg::SICM_BUS_IDLE:
        begin
          if (wb_cyc_i && wb_stb_i)
          begin
            bus_state_q <= sicm_pkg::SICM_BUS_WAIT;
          end
        end
        sicm_pkg::SICM_BUS_WAIT: bus_state_q <= sicm_pkg::SICM_BUS_ACK;
        sicm_pkg::SICM_BUS_ACK:  bus_state_q <= sicm_pkg::SICM_BUS_IDLE;
        default:                 bus_state_q <= sicm_pkg::SICM_BUS_IDLE;
      endcase
    end
  end

  // Write strobe: only at the edge where the master samples ack high
  assign mem_we = (bus_state_q == sicm_pkg::SICM_BUS_ACK) && wb_cyc_i && wb_stb_i
                  && wb_we_i && bus_hit;

  // Lower word lives in bits 15:0, upper word in bits 31:16 of an entry
  always_comb
  begin
    if (bus_high)
    begin
      mem_be    = {wb_sel_i[1:0], 2'b00};
      mem_wdata = {wb_dat_i[15:0], 16'h0000};
    end
    else
    begin
      mem_be    = {2'b00, wb_sel_i[1:0]};
      mem_wdata = {16'h0000, wb_dat_i[15:0] & sicm_pkg::LOW_USED_MASK};
    end
  end

  // Readback mux; unused lower-word bits and upper lanes read zero
  always_comb
  begin
    rd_word = sicm_pkg::READ_ZERO;
    if (bus_hit && bus_high)
    begin
      rd_word[15:0] = mem_a_data[31:16];
    end
    else if (bus_hit)
    begin
      rd_word[15:0] = mem_a_data[15:0] & sicm_pkg::LOW_USED_MASK;
    end
    else if (bus_status)
    begin
      rd_word[sicm_pkg::ST_STAGE_LSB +: sicm_pkg::STAGE_W] = stage_q;
      rd_word[sicm_pkg::ST_FAULT_BIT] = mode_fault_q;
      rd_word[sicm_pkg::ST_BUSY_BIT]  = stage_busy_q;
    end
  end

  // Read data and ack are both registered; unmapped reads return zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_dat_q <= sicm_pkg::READ_ZERO;
      wb_ack_q <= 1'b0;
    end
    else
    begin
      wb_ack_q <= (bus_state_q == sicm_pkg::SICM_BUS_WAIT) && wb_cyc_i && wb_stb_i;
      if (bus_state_q == sicm_pkg::SICM_BUS_WAIT && !wb_we_i)
      begin
        wb_dat_q <= rd_word;
      end
    end
  end

  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;

  // ------------------------------------------------------------------
  // Storage: bus on port A, sequencer on port B
  // ------------------------------------------------------------------
  sicm_stage_mem #(
    .DEPTH (NUM_STAGES),
    .AW    (sicm_pkg::STAGE_W),
    .WIDTH (32)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (bus_stage),
    .wr_be   (mem_be),
    .wr_data (mem_wdata),
    .a_addr  (bus_stage),
    .a_data  (mem_a_data),
    .b_addr  (stage_q),
    .b_data  (mem_b_data)
  );

  // ------------------------------------------------------------------
  // Sequencer side
  // ------------------------------------------------------------------
  sicm_pkg::sicm_stg_state_t stg_state_q;
  logic                  stage_ready_q;
  logic [NUM_INPUTS-1:0] route_neg_q;
  logic [NUM_INPUTS-1:0] route_pos_q;
  logic [NUM_INPUTS-1:0] route_bias_q;
  logic [NUM_INPUTS-1:0] route_neg_d;
  logic [NUM_INPUTS-1:0] route_pos_d;
  logic [NUM_INPUTS-1:0] route_bias_d;
  logic [1:0]            mode_q;
  logic                  neg_off_en_q;
  logic                  pos_off_en_q;
  logic [sicm_pkg::OFFSET_W-1:0] neg_code_q;
  logic [sicm_pkg::OFFSET_W-1:0] pos_code_q;
  logic [15:0]           low_word;
  logic [15:0]           high_word;
  logic [1:0]            mode_d;

  assign low_word  = mem_b_data[15:0];
  assign high_word = mem_b_data[31:16];
  assign mode_d    = high_word[sicm_pkg::MODE_LSB +: 2];

  // Stage fetch; requests for a missing stage or while busy are dropped
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stg_state_q  <= sicm_pkg::SICM_STG_IDLE;
      stage_q      <= '0;
      stage_busy_q <= 1'b0;
    end
    else
    begin
      unique case (stg_state_q)
        sicm_pkg::SICM_STG_IDLE:
        begin
          if (stage_load && int'(stage_sel) < NUM_STAGES)
          begin
            stage_q      <= stage_sel;
            stage_busy_q <= 1'b1;
            stg_state_q  <= sicm_pkg::SICM_STG_FETCH;
          end
        end
        sicm_pkg::SICM_STG_FETCH: stg_state_q <= sicm_pkg::SICM_STG_APPLY;
        sicm_pkg::SICM_STG_APPLY:
        begin
          stage_busy_q <= 1'b0;
          stg_state_q  <= sicm_pkg::SICM_STG_IDLE;
        end
        default: stg_state_q <= sicm_pkg::SICM_STG_IDLE;
      endcase
    end
  end

  // Per-input switch decode across both words
  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_route
    logic [1:0] sel;
    logic [2:0] r;
    if (i < sicm_pkg::LOW_INPUTS)
    begin : g_low
      assign sel = low_word[2*i +: 2];
    end
    else
    begin : g_high
      assign sel = high_word[2*(i-sicm_pkg::LOW_INPUTS) +: 2];
    end
    assign r               = decode_route(sel);
    assign route_neg_d[i]  = r[0];
    assign route_pos_d[i]  = r[1];
    assign route_bias_d[i] = r[2];
  end

  // Switch matrix state, updated only at the end of the APPLY cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      route_neg_q  <= '0;
      route_pos_q  <= '0;
      route_bias_q <= '0;
    end
    else if (stg_state_q == sicm_pkg::SICM_STG_APPLY)
    begin
      route_neg_q  <= route_neg_d;
      route_pos_q  <= route_pos_d;
      route_bias_q <= route_bias_d;
    end
  end

  // Mode passes through; forbidden code is flagged, not corrected
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_q       <= sicm_pkg::MODE_DIFF;
      mode_fault_q <= 1'b0;
    end
    else if (stg_state_q == sicm_pkg::SICM_STG_APPLY)
    begin
      mode_q       <= mode_d;
      mode_fault_q <= (mode_d == sicm_pkg::MODE_FORBIDDEN);
    end
  end

  // Offset paths: a disabled path carries a zero code
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      neg_off_en_q <= 1'b0;
      pos_off_en_q <= 1'b0;
      neg_code_q   <= '0;
      pos_code_q   <= '0;
    end
    else if (stg_state_q == sicm_pkg::SICM_STG_APPLY)
    begin
      neg_off_en_q <= !high_word[sicm_pkg::NEG_OFF_BIT];
      pos_off_en_q <= !high_word[sicm_pkg::POS_OFF_BIT];
      neg_code_q   <= high_word[sicm_pkg::NEG_OFF_BIT] ? '0 : neg_frontend_offset_value;
      pos_code_q   <= high_word[sicm_pkg::POS_OFF_BIT] ? '0 : pos_frontend_offset_value;
    end
  end

  // One-cycle pulse when the new stage setup is on the outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage_ready_q <= 1'b0;
    end
    else
    begin
      stage_ready_q <= (stg_state_q == sicm_pkg::SICM_STG_APPLY);
    end
  end

  assign stage_ready            = stage_ready_q;
  assign stage_busy             = stage_busy_q;
  assign sensor_input_to_neg    = route_neg_q;
  assign sensor_input_to_pos    = route_pos_q;
  assign sensor_input_to_bias   = route_bias_q;
  assign measurement_mode_sel   = mode_q;
  assign mode_fault             = mode_fault_q;
  assign neg_frontend_offset_en = neg_off_en_q;
  assign pos_frontend_offset_en = pos_off_en_q;
  assign neg_offset_code        = neg_code_q;
  assign pos_offset_code        = pos_code_q;

endmodule

// [sim/sicm_asserts.sv]
// Port checker for the stage input connection matrix.
// Assumes one clock domain and an active-high async reset; bound to sicm_top.
`timescale 1ns/1ps
module sicm_asserts #(
  parameter int NUM_INPUTS = 13
) (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [11:0]            wb_adr_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   stage_load,
  input wire logic [3:0]             stage_sel,
  input wire logic                   stage_ready,
  input wire logic                   stage_busy,
  input wire logic [NUM_INPUTS-1:0]  sensor_input_to_neg,
  input wire logic [NUM_INPUTS-1:0]  sensor_input_to_pos,
  input wire logic [NUM_INPUTS-1:0]  sensor_input_to_bias,
  input wire logic [1:0]             measurement_mode_sel,
  input wire logic                   mode_fault,
  input wire logic                   neg_frontend_offset_en,
  input wire logic                   pos_frontend_offset_en,
  input wire logic [5:0]             neg_offset_code,
  input wire logic [5:0]             pos_offset_code
);
  // Lower connection word of stages 0 to 11 is addressed
  logic low_hit;
  assign low_hit = (wb_adr_i[11:9] == 3'h1) && (wb_adr_i[8:5] < 4'hc) && (wb_adr_i[4:2] == 3'h0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_delay: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:3] wb_ack_o)
    else $error("bus request not answered in time");
  chk_low_unused: assert property (wb_ack_o && !wb_we_i && low_hit |-> wb_dat_o[31:14] == 18'h0_0000)
    else $error("unused lower word bits read non-zero");
  chk_route_excl: assert property (((sensor_input_to_neg & sensor_input_to_pos) == '0)
    && ((sensor_input_to_bias & (sensor_input_to_neg | sensor_input_to_pos)) == '0))
    else $error("sensor input closed onto two nodes");
  chk_out_hold: assert property ($changed({sensor_input_to_neg, sensor_input_to_pos,
    sensor_input_to_bias, measurement_mode_sel}) |-> $fell(stage_busy))
    else $error("switch outputs changed outside a stage load");
  chk_neg_gate: assert property (!neg_frontend_offset_en |-> neg_offset_code == 6'h00)
    else $error("negative offset code while path disabled");
  chk_pos_gate: assert property (!pos_frontend_offset_en |-> pos_offset_code == 6'h00)
    else $error("positive offset code while path disabled");
  chk_fault_mode: assert property (!stage_busy |-> mode_fault == (measurement_mode_sel == 2'h0))
    else $error("mode fault flag does not match mode");
  chk_ready_delay: assert property (stage_load && !stage_busy && stage_sel < 4'hc |-> ##[2:4] stage_ready)
    else $error("stage load not completed in time");
  chk_bad_stage: assert property (stage_load && !stage_busy && stage_sel >= 4'hc |=> !stage_busy)
    else $error("load of a missing stage was taken");

  // Main scenarios reached
  cover property (wb_ack_o && wb_we_i);
  cover property (stage_ready);
  cover property (stage_ready && mode_fault);
endmodule

bind sicm_top sicm_asserts #(.NUM_INPUTS(NUM_INPUTS)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stage_load(stage_load),
  .stage_sel(stage_sel), .stage_ready(stage_ready), .stage_busy(stage_busy),
  .sensor_input_to_neg(sensor_input_to_neg), .sensor_input_to_pos(sensor_input_to_pos),
  .sensor_input_to_bias(sensor_input_to_bias), .measurement_mode_sel(measurement_mode_sel),
  .mode_fault(mode_fault), .neg_frontend_offset_en(neg_frontend_offset_en),
  .pos_frontend_offset_en(pos_frontend_offset_en), .neg_offset_code(neg_offset_code),
  .pos_offset_code(pos_offset_code));

// [sim/sicm_tb_top.sv]
// Self-checking bench for the stage input connection matrix.
// Assumes the bench alone drives the Wishbone and sequencer ports.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module sicm_tb_top;
  logic        clk                       = 1'h0;
  logic        sys_rst                   = 1'h1;
  logic        wb_cyc_i                  = 1'h0;
  logic        wb_stb_i                  = 1'h0;
  logic        wb_we_i                   = 1'h0;
  logic [11:0] wb_adr_i                  = 12'h000;
  logic [3:0]  wb_sel_i                  = 4'h0;
  logic [31:0] wb_dat_i                  = 32'h0000_0000;
  logic        stage_load                = 1'h0;
  logic [3:0]  stage_sel                 = 4'h0;
  logic [5:0]  neg_frontend_offset_value = 6'h00;
  logic [5:0]  pos_frontend_offset_value = 6'h00;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        stage_ready;
  logic        stage_busy;
  logic [12:0] sensor_input_to_neg;
  logic [12:0] sensor_input_to_pos;
  logic [12:0] sensor_input_to_bias;
  logic [1:0]  measurement_mode_sel;
  logic        mode_fault;
  logic        neg_frontend_offset_en;
  logic        pos_frontend_offset_en;
  logic [5:0]  neg_offset_code;
  logic [5:0]  pos_offset_code;
  logic [12:0] s1_neg;
  int          fail_count                = 0;
  int          cmp_count                 = 0;
  int          cycles                    = 0;

  sicm_top u_dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stage_load(stage_load), .stage_sel(stage_sel),
    .neg_frontend_offset_value(neg_frontend_offset_value),
    .pos_frontend_offset_value(pos_frontend_offset_value), .stage_ready(stage_ready),
    .stage_busy(stage_busy), .sensor_input_to_neg(sensor_input_to_neg),
    .sensor_input_to_pos(sensor_input_to_pos), .sensor_input_to_bias(sensor_input_to_bias),
    .measurement_mode_sel(measurement_mode_sel), .mode_fault(mode_fault),
    .neg_frontend_offset_en(neg_frontend_offset_en), .pos_frontend_offset_en(pos_frontend_offset_en),
    .neg_offset_code(neg_offset_code), .pos_offset_code(pos_offset_code));

  // 125 MHz clock
  always #4 clk = ~clk;

  // Hang guard; the tests need about 150 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Word index of a stage word: base 0x080, eight words per stage
  function automatic logic [9:0] idx_of(input int s, input int w);
    return 10'h080 + 10'(8 * s + w);
  endfunction

  // One classic cycle; idle edge first so strobes drop between cycles
  task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk);
    end
    while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    `CHK("wb_ack_o", 1'h1, wb_ack_o)
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  // Pulse a stage load and wait for the ready pulse; outputs valid at that edge
  task automatic run_stage(input logic [3:0] s, output logic seen);
    int n;
    n = 0;
    @(posedge clk);
    stage_load <= 1'h1;
    stage_sel  <= s;
    @(posedge clk);
    stage_load <= 1'h0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (stage_ready !== 1'h1 && n < 8);
    seen = (stage_ready === 1'h1);
  endtask

  // Read-back, unused bits, byte lanes and an unmapped word inside the stage 0 window
  task automatic t_regs();
    logic [31:0] r;
    wb_xfer(1'h1, idx_of(0, 0), 4'h3, 32'hffff_ffff, r);
    wb_xfer(1'h0, idx_of(0, 0), 4'hf, 32'h0000_0000, r);
    `CHK("low word", 32'h0000_3fff, r)
    wb_xfer(1'h1, idx_of(11, 1), 4'h3, 32'h0000_a5c3, r);
    wb_xfer(1'h1, idx_of(11, 1), 4'h1, 32'h0000_ff3c, r);
    wb_xfer(1'h0, idx_of(11, 1), 4'hf, 32'h0000_0000, r);
    `CHK("high word", 32'h0000_a53c, r)
    wb_xfer(1'h1, 10'h082, 4'h3, 32'h0000_1234, r);
    wb_xfer(1'h0, 10'h082, 4'hf, 32'h0000_0000, r);
    `CHK("unmapped", 32'h0000_0000, r)
  endtask

  // Every code on every input, rotated over stages 1 to 4
  task automatic t_routes();
    logic [31:0] r;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [12:0] en;
    logic [12:0] ep;
    logic [12:0] eb;
    logic [1:0]  c;
    logic        seen;
    for (int sh = 0; sh < 4; sh++)
    begin
      lo = 16'h0000;
      hi = 16'h3000;
      for (int i = 0; i < 13; i++)
      begin
        c = 2'((i + sh) % 4);
        if (i < 7)
          lo[2*i +: 2] = c;
        else
          hi[2*(i-7) +: 2] = c;
        en[i] = (c == 2'h1);
        ep[i] = (c == 2'h2);
        eb[i] = (c == 2'h3);
      end
      if (sh == 0)
        s1_neg = en;
      wb_xfer(1'h1, idx_of(sh + 1, 0), 4'h3, {16'h0000, lo}, r);
      wb_xfer(1'h1, idx_of(sh + 1, 1), 4'h3, {16'h0000, hi}, r);
      run_stage(4'(sh + 1), seen);
      `CHK("ready", 1'h1, seen)
      `CHK("to_neg", en, sensor_input_to_neg)
      `CHK("to_pos", ep, sensor_input_to_pos)
      `CHK("to_bias", eb, sensor_input_to_bias)
      `CHK("open", ~(en | ep | eb), ~(sensor_input_to_neg | sensor_input_to_pos | sensor_input_to_bias))
    end
  endtask

  // All mode codes, each with one of the four offset-disable pairs
  task automatic t_modes();
    logic [31:0] r;
    logic [1:0]  m;
    logic        seen;
    wb_xfer(1'h1, idx_of(5, 0), 4'h3, 32'h0000_3fff, r);
    for (int k = 0; k < 4; k++)
    begin
      m = 2'(k);
      wb_xfer(1'h1, idx_of(5, 1), 4'h3, {16'h0000, m[1], m[0], m, 12'hfff}, r);
      @(posedge clk);
      neg_frontend_offset_value <= 6'(9 * k + 5);
      pos_frontend_offset_value <= 6'(7 * k + 33);
      run_stage(4'h5, seen);
      `CHK("mode", m, measurement_mode_sel)
      `CHK("fault", (m == 2'h0), mode_fault)
      `CHK("neg_en", ~m[0], neg_frontend_offset_en)
      `CHK("pos_en", ~m[1], pos_frontend_offset_en)
      `CHK("neg_code", m[0] ? 6'h00 : 6'(9 * k + 5), neg_offset_code)
      `CHK("pos_code", m[1] ? 6'h00 : 6'(7 * k + 33), pos_offset_code)
    end
  endtask

  // Missing stage and a load while busy are both dropped
  task automatic t_refuse();
    logic        seen;
    logic [31:0] r;
    run_stage(4'hc, seen);
    `CHK("stage 12 ready", 1'h0, seen)
    `CHK("mode kept", 2'h3, measurement_mode_sel)
    @(posedge clk);
    stage_load <= 1'h1;
    stage_sel  <= 4'h1;
    @(posedge clk);
    stage_sel  <= 4'h2;
    @(posedge clk);
    stage_load <= 1'h0;
    `CHK("busy", 1'h1, stage_busy)
    repeat (8) @(posedge clk);
    `CHK("busy load", s1_neg, sensor_input_to_neg)
    `CHK("idle", 1'h0, stage_busy)
    // Status word: last stage 1, no fault, not busy
    wb_xfer(1'h0, 10'h060, 4'hf, 32'h0000_0000, r);
    `CHK("status", 32'h0000_0001, r)
  endtask

  // Reset for two cycles, then the scenarios
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    `CHK("reset mode", 2'h3, measurement_mode_sel)
    `CHK("reset ack", 1'h0, wb_ack_o)
    t_regs();
    t_routes();
    t_modes();
    t_refuse();
    summarize();
  end
endmodule
